// ---- rtl/tone_gen.sv ----
// dual tone generator core: two sine synthesizers and a melody square wave
// assumes clk_i is the crystal clock and port logic outside owns the shared pin
// when the melody pin output enable is high
`timescale 1ns/1ps
`include "tone_gen_map.svh"
module tone_gen (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic [8:0] tone_o,
    output logic tone_oe_n_o,
    output logic melody_pin_o,
    output logic melody_pin_oe_n_o,
    output logic gen_on_o
);
    import tone_gen_pkg::*;

    tone_gen_pkg::tone_state_t s_q;
    tone_gen_pkg::tone_state_t s_d;
    logic [1:0][7:0] sample;
    logic [1:0][7:0] code;
    logic signed [17:0] low_prod;
    logic signed [8:0] high_ext;
    logic signed [8:0] low_ext;

    // ----------------------------------------
    // sine tables, one per synthesizer
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            sine_rom u_rom (
                .clk_i(clk_i),
                .addr_i(s_q.phase[g]),
                .data_o(sample[g])
            );
        end
    endgenerate

    assign code[0] = s_q.high_group_frequency;
    assign code[1] = s_q.low_group_frequency;

    // ----------------------------------------
    // amplitude scaling and sum
    // ----------------------------------------
    always_comb begin
        high_ext = (s_q.period[0] != `TG_ZERO_BYTE) ? {sample[0][7], sample[0]} : 9'sh000;
        low_prod = $signed({sample[1][7], sample[1]}) * $signed(`TG_LOW_GAIN);
        low_ext = (s_q.period[1] != `TG_ZERO_BYTE) ? {low_prod[15], low_prod[15:8]} : 9'sh000;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        // register writes
        if (wr_i) begin
            case (addr_i)
                `TG_ADDR_HIGH: s_d.high_group_frequency = wdata_i;
                `TG_ADDR_LOW: s_d.low_group_frequency = wdata_i;
                `TG_ADDR_MELODY: s_d.melody_output_enable = wdata_i[`TG_MELODY_BIT];
                default: ;
            endcase
        end
        // reads, data in the next cycle only
        s_d.rdata = `TG_ZERO_BYTE;
        if (rd_i) begin
            case (addr_i)
                `TG_ADDR_MELODY: s_d.rdata[`TG_MELODY_BIT] = s_q.melody_output_enable;
                `TG_ADDR_STATUS: begin
                    s_d.rdata[`TG_STAT_GEN_ON] = s_q.gen_on;
                    s_d.rdata[`TG_STAT_MELODY] = s_q.melody_pin;
                    s_d.rdata[`TG_STAT_HIGH_RUN] = (s_q.period[0] != `TG_ZERO_BYTE);
                    s_d.rdata[`TG_STAT_LOW_RUN] = (s_q.period[1] != `TG_ZERO_BYTE);
                end
                default: ;
            endcase
        end
        // synthesizers: divider by x+2, then 23 phase steps
        for (int i = 0; i < 2; i++) begin
            if (s_q.period[i] == `TG_ZERO_BYTE) begin
                s_d.period[i] = code[i];
                s_d.div_cnt[i] = 9'h000;
                s_d.phase[i] = 5'h00;
            end else if (s_q.div_cnt[i] == {1'b0, s_q.period[i]} + `TG_DIV_EXTRA) begin
                s_d.div_cnt[i] = 9'h000;
                if (s_q.phase[i] == `TG_LAST_STEP) begin
                    s_d.phase[i] = 5'h00;
                    s_d.period[i] = code[i];
                end else begin
                    s_d.phase[i] = s_q.phase[i] + 5'h01;
                end
            end else begin
                s_d.div_cnt[i] = s_q.div_cnt[i] + 9'h001;
            end
        end
        s_d.gen_on = (s_q.period[0] != `TG_ZERO_BYTE) || (s_q.period[1] != `TG_ZERO_BYTE);
        s_d.tone = s_q.gen_on ? 9'(high_ext + low_ext) : 9'h000;
        // tone driver: off when idle or melody in use
        s_d.tone_oe_n = s_q.melody_output_enable || !s_d.gen_on;
        // melody pin, sines keep running meanwhile
        s_d.melody_pin_oe_n = !s_q.melody_output_enable;
        if (s_q.high_group_frequency == `TG_ZERO_BYTE || s_q.period[0] == `TG_ZERO_BYTE) begin
            s_d.melody_pin = 1'b1;
        end else begin
            s_d.melody_pin = (s_q.phase[0] < `TG_HIGH_STEPS);
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
            s_q.tone_oe_n <= 1'b1;
            s_q.melody_pin <= 1'b1;
            s_q.melody_pin_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign tone_o = s_q.tone;
    assign tone_oe_n_o = s_q.tone_oe_n;
    assign melody_pin_o = s_q.melody_pin;
    assign melody_pin_oe_n_o = s_q.melody_pin_oe_n;
    assign gen_on_o = s_q.gen_on;
endmodule

// ---- include/tone_gen_map.svh ----
// register map, field positions and step counts for the tone generator
// assumes a byte-wide register port and the core clock as the crystal clock
`ifndef TONE_GEN_MAP_SVH
`define TONE_GEN_MAP_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define TG_ADDR_HIGH 8'h11
`define TG_ADDR_LOW 8'h12
`define TG_ADDR_MELODY 8'h13
`define TG_ADDR_STATUS 8'h14

// ----------------------------------------
// fields
// ----------------------------------------
`define TG_MELODY_BIT 0
`define TG_STAT_GEN_ON 0
`define TG_STAT_MELODY 1
`define TG_STAT_HIGH_RUN 2
`define TG_STAT_LOW_RUN 3

// ----------------------------------------
// timing and shaping
// ----------------------------------------
`define TG_DIV_EXTRA 9'h001
`define TG_LAST_STEP 5'h16
`define TG_HIGH_STEPS 5'h0c
`define TG_LOW_GAIN 9'h0cb
`define TG_ZERO_BYTE 8'h00

`endif

// ---- include/tone_gen_pkg.sv ----
// types of the tone generator core
// assumes tone_gen_map.svh supplies the constants used with these types
package tone_gen_pkg;

    typedef struct packed {
        logic [7:0] high_group_frequency;
        logic [7:0] low_group_frequency;
        logic melody_output_enable;
        logic [1:0][7:0] period;
        logic [1:0][8:0] div_cnt;
        logic [1:0][4:0] phase;
        logic [8:0] tone;
        logic tone_oe_n;
        logic melody_pin;
        logic melody_pin_oe_n;
        logic gen_on;
        logic [7:0] rdata;
    } tone_state_t;

endpackage

// ---- rtl/sine_rom.sv ----
// one period of a signed sine, 23 samples, registered read
// assumes the address stays below 23; other addresses read zero
`timescale 1ns/1ps
module sine_rom (
    input wire logic clk_i,
    input wire logic [4:0] addr_i,
    output logic [7:0] data_o
);
    // ----------------------------------------
    // table and read register
    // ----------------------------------------
    logic [7:0] word;

    always_comb begin
        case (addr_i)
            5'h00: word = 8'h00;
            5'h01: word = 8'h22;
            5'h02: word = 8'h42;
            5'h03: word = 8'h5d;
            5'h04: word = 8'h71;
            5'h05: word = 8'h7c;
            5'h06: word = 8'h7f;
            5'h07: word = 8'h78;
            5'h08: word = 8'h68;
            5'h09: word = 8'h50;
            5'h0a: word = 8'h33;
            5'h0b: word = 8'h11;
            5'h0c: word = 8'hef;
            5'h0d: word = 8'hcd;
            5'h0e: word = 8'hb0;
            5'h0f: word = 8'h98;
            5'h10: word = 8'h88;
            5'h11: word = 8'h81;
            5'h12: word = 8'h84;
            5'h13: word = 8'h8f;
            5'h14: word = 8'ha3;
            5'h15: word = 8'hbe;
            5'h16: word = 8'hde;
            default: word = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        data_o <= word;
    end
endmodule

// ---- test/tone_gen_properties.sv ----
// port assertions for tone_gen
// assumes a bind onto tone_gen, one clock
`timescale 1ns/1ps
module tone_gen_properties (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [8:0] tone_o,
    input wire logic tone_oe_n_o,
    input wire logic melody_pin_o,
    input wire logic melody_pin_oe_n_o,
    input wire logic gen_on_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence hi_wr;
        wr_i && addr_i == 8'h11;
    endsequence
    chk_mel_tri: assert property (!melody_pin_oe_n_o |-> tone_oe_n_o)
        else $error("tone on in melody");
    chk_idle_tri: assert property (!gen_on_o |-> tone_oe_n_o)
        else $error("tone on when idle");
    chk_port_en: assert property (melody_pin_oe_n_o && gen_on_o |-> !tone_oe_n_o)
        else $error("tone not enabled");
    chk_mel_sel: assert property (wr_i && addr_i == 8'h13 |->
        ##2 melody_pin_oe_n_o == !$past(wdata_i[0], 2))
        else $error("pin enable wrong");
    chk_pin_zero: assert property (hi_wr and wdata_i == 8'h00 |-> ##2 melody_pin_o)
        else $error("pin not high");
    chk_wo_read: assert property (rd_i && (addr_i == 8'h11 || addr_i == 8'h12) |=> rdata_o == 8'h00)
        else $error("code readable");
    chk_off_zero: assert property (!gen_on_o [*3] |-> tone_o == 9'h000)
        else $error("tone not zero");
    chk_hi_start: assert property (hi_wr and wdata_i != 8'h00 && !gen_on_o |-> ##3 gen_on_o)
        else $error("no start");
endmodule

// ---- test/reg_master.sv ----
// software side: register bus master
// assumes strobes change just after rising edges
`timescale 1ns/1ps
module reg_master (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // callers keep nonzero codes at 2 or more, 0 stops a synthesizer
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic r(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule

// ---- test/tone_gen_tb.sv ----
// self-checking bench for tone_gen
// assumes reg_master for bus cycles
`timescale 1ns/1ps
module tone_gen_tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr, wdata, rdata, v, rnd;
    logic [8:0] tone;
    logic wr, rd, oe_n, pin, pin_oe_n, gen_on;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int x;
    int code_m [2] = '{0, 0};
    int mel_m = 0;
    reg_master bus (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    tone_gen tone_gen_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .tone_o(tone), .tone_oe_n_o(oe_n), .melody_pin_o(pin),
        .melody_pin_oe_n_o(pin_oe_n), .gen_on_o(gen_on));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // model of the written registers, kept beside every bus write
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        bus.w(a, d);
        if (a == 8'h11) code_m[0] = int'(d);
        if (a == 8'h12) code_m[1] = int'(d);
        if (a == 8'h13) mel_m = int'(d[0]);
    endtask
    function automatic logic [15:0] stat_m(input int pin_m);
        return 16'((code_m[1] != 0) * 8 + (code_m[0] != 0) * 4 + pin_m * 2 + (code_m[0] != 0 || code_m[1] != 0));
    endfunction
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic measure(input int c);
        int h = 0;
        int p = 0;
        repeat (2) begin
            while (pin !== 1'b0) @(negedge clk_i);
            while (pin !== 1'b1) @(negedge clk_i);
        end
        while (pin === 1'b1) begin
            h++;
            @(negedge clk_i);
        end
        while (pin === 1'b0) begin
            p++;
            @(negedge clk_i);
        end
        check("high", 16'(12 * (c + 2)), 16'(h));
        check("period", 16'(23 * (c + 2)), 16'(h + p));
    endtask
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        rnd = 8'h53;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        bus.r(8'h14, v);
        check("idle", stat_m(1), 16'(v));
        put(8'h13, 8'h01);
        bus.r(8'h13, v);
        check("mode", 16'(mel_m), 16'(v));
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            x = (i == 0) ? 2 : 2 + rnd[2:0];
            put(8'h11, 8'(x));
            bus.r(8'h11, v);
            check("wo", 16'h0000, 16'(v));
            measure(x);
            check("run", 16'h0003, {14'h0000, gen_on, oe_n});
        end
        put(8'h11, 8'h00);
        repeat (3) @(posedge clk_i);
        check("pin", 16'h0001, {15'h0000, pin});
        put(8'h13, 8'h00);
        put(8'h12, 8'hdd);
        put(8'h11, 8'h7f);
        repeat (300) @(posedge clk_i);
        check("en", 16'h0001, {14'h0000, oe_n, pin_oe_n});
        bus.r(8'h14, v);
        check("both", stat_m(0) & 16'h00fd, 16'(v & 8'hfd));
        put(8'h11, 8'h00);
        repeat (3000) @(posedge clk_i);
        bus.r(8'h14, v);
        check("low", stat_m(1), 16'(v));
        put(8'h12, 8'h00);
        repeat (5200) @(posedge clk_i);
        bus.r(8'h14, v);
        check("off", stat_m(1), 16'(v));
        check("tone", 16'h0000, {7'h00, tone});
        put(8'h11, 8'h44);
        measure(68);
        bus.r(8'h14, v);
        check("modem", stat_m(0) & 16'h00fd, 16'(v & 8'hfd));
        close_out();
    end
endmodule
bind tone_gen tone_gen_properties tone_gen_properties_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tone_o(tone_o),
    .tone_oe_n_o(tone_oe_n_o), .melody_pin_o(melody_pin_o), .melody_pin_oe_n_o(melody_pin_oe_n_o),
    .gen_on_o(gen_on_o));
